//--- core/srr_exec.sv
// executor for literal return, plain return and rotate left through carry
`timescale 1ns/1ps
module srr_exec
    import srr_pkg::*;
(
    // clock and control
    input  wire logic                ref_clk_in,
    input  wire logic                rst_in,
    input  wire logic                clk_en_in,
    // instruction from decoder
    input  wire logic                insn_valid_in,
    input  wire logic [INSN_W-1:0]   insn_in,
    // operands from core
    input  wire logic [DATA_W-1:0]   file_rd_data_in,
    input  wire logic                carry_in,
    input  wire logic [PC_W-1:0]     stack_top_entry_in,
    // decoder stall and writeback
    output logic                     busy_out,
    output srr_wb_t                  wb_out,
    output logic                     carry_wr_out,
    output logic                     carry_out,
    output srr_ret_t                 ret_out
);
    // ======================================================================
    // field positions, derived from the opcode constants so that the
    // slices below cannot drift away from the encodings
    localparam int RETLIT_TOP_W = $bits(OP_RETLIT_TOP);
    localparam int ROTL_TOP_W   = $bits(OP_ROTL_TOP);
    localparam int RETLIT_LSB   = INSN_W - RETLIT_TOP_W;
    localparam int ROTL_LSB     = INSN_W - ROTL_TOP_W;
    // a return spends its first cycle in idle, the rest are dead slots
    localparam int DEAD_SLOTS   = RET_CYCLES - 1;
    localparam int LAST_SLOT    = DEAD_SLOTS - 1;
    localparam int SLOT_W       = (DEAD_SLOTS > 1) ? $clog2(DEAD_SLOTS) : 1;

    // ======================================================================
    // elaboration checks
    if (DEAD_SLOTS < 1) begin : g_bad_cycles
        $error("srr_exec: a return needs at least one dead cycle");
    end
    if (LIT_LSB + DATA_W > RETLIT_LSB) begin : g_bad_literal
        $error("srr_exec: literal field overlaps the opcode");
    end
    if (FADDR_LSB + FADDR_W > DEST_BIT) begin : g_bad_faddr
        $error("srr_exec: file address overlaps the destination bit");
    end
    if (DEST_BIT >= ROTL_LSB) begin : g_bad_dest
        $error("srr_exec: destination bit overlaps the opcode");
    end
    if (MSB_BIT != DATA_W - 1) begin : g_bad_msb
        $error("srr_exec: carry must leave from the data msb");
    end
    if ($bits(OP_RETURN) != INSN_W) begin : g_bad_return
        $error("srr_exec: return encoding must span the instruction word");
    end
    if (OP_ROTL_TOP[ROTL_TOP_W-1 -: RETLIT_TOP_W] == OP_RETLIT_TOP) begin : g_bad_opcodes
        $error("srr_exec: rotate and literal return opcodes collide");
    end

    // ======================================================================
    // declarations
    srr_state_t        state;
    srr_state_t        next_state;
    logic              busy;
    logic              next_busy;
    logic [SLOT_W-1:0] slot_cnt;
    logic [SLOT_W-1:0] next_slot_cnt;
    srr_wb_t           wb;
    srr_wb_t           next_wb;
    logic              carry_wr;
    logic              next_carry_wr;
    logic              carry_q;
    logic              next_carry_q;
    srr_ret_t          ret;
    srr_ret_t          next_ret;
    logic              in_idle;
    logic              is_retlit;
    logic              is_return;
    logic              is_rotl;
    logic              take_retlit;
    logic              take_ret;
    logic              take_rotl;
    logic [DATA_W-1:0] rot_res;
    logic              rot_c;

    // ======================================================================
    // decode: an instruction is only taken in idle, so the word fetched
    // behind a return is dropped here even if the decoder forgets to flush
    always_comb begin
        in_idle     = (state == SRR_IDLE);
        is_retlit   = insn_valid_in && (insn_in[RETLIT_LSB +: RETLIT_TOP_W] == OP_RETLIT_TOP);
        is_return   = insn_valid_in && (insn_in == OP_RETURN);
        is_rotl     = insn_valid_in && (insn_in[ROTL_LSB +: ROTL_TOP_W] == OP_ROTL_TOP);
        take_retlit = in_idle && is_retlit;
        take_ret    = in_idle && (is_retlit || is_return);
        take_rotl   = in_idle && is_rotl;
    end

    // rotate datapath: purely combinational, its result is registered
    // together with the other writeback fields

    srr_rotate #(.WIDTH(DATA_W)) u_rot (
        .value_in   (file_rd_data_in),
        .carry_in   (carry_in),
        .result_out (rot_res),
        .carry_out  (rot_c)
    );

    // ======================================================================
    // control: the second cycle of a return is a dead slot, busy tells the
    // decoder to discard the word it fetched behind the return
    always_comb begin
        next_state    = state;
        next_busy     = 1'b0;
        next_slot_cnt = slot_cnt;
        case (state)
            SRR_IDLE: begin
                if (take_ret) begin
                    next_state    = SRR_RETURN;
                    next_busy     = 1'b1;
                    next_slot_cnt = '0;
                end
            end
            SRR_RETURN: begin
                if (slot_cnt == SLOT_W'(LAST_SLOT)) begin
                    next_state = SRR_IDLE;
                end else begin
                    next_busy     = 1'b1;
                    next_slot_cnt = slot_cnt + 1'b1;
                end
            end
            default: begin
                next_state = SRR_IDLE;
            end
        endcase
    end

    // a low enable holds every register, reset still wins over it
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            state    <= SRR_IDLE;
            busy     <= 1'b0;
            slot_cnt <= '0;
        end else if (clk_en_in) begin
            state    <= next_state;
            busy     <= next_busy;
            slot_cnt <= next_slot_cnt;
        end
    end

    // ======================================================================
    // writeback: strobes last one cycle, data is meaningless without one;
    // the file address stays zero on a literal return
    always_comb begin
        next_wb = '0;
        if (take_retlit) begin
            next_wb.wr_acc    = 1'b1;
            next_wb.data      = insn_in[LIT_LSB +: DATA_W];
        end else if (take_rotl) begin
            next_wb.data      = rot_res;
            next_wb.file_addr = insn_in[FADDR_LSB +: FADDR_W];
            next_wb.wr_file   = insn_in[DEST_BIT];
            next_wb.wr_acc    = !insn_in[DEST_BIT];
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            wb <= '0;
        end else if (clk_en_in) begin
            wb <= next_wb;
        end
    end

    // ======================================================================
    // carry: only the rotate writes it, returns leave every flag alone
    always_comb begin
        next_carry_wr = 1'b0;
        next_carry_q  = carry_q;
        if (take_rotl) begin
            next_carry_wr = 1'b1;
            next_carry_q  = rot_c;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            carry_wr <= 1'b0;
            carry_q  <= 1'b0;
        end else if (clk_en_in) begin
            carry_wr <= next_carry_wr;
            carry_q  <= next_carry_q;
        end
    end

    // ======================================================================
    // return: the popped address travels with the pop strobe and is zero
    // otherwise, so a stale address never reaches the program counter
    always_comb begin
        next_ret = '0;
        if (take_ret) begin
            next_ret.pop = 1'b1;
            next_ret.pc  = stack_top_entry_in;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            ret <= '0;
        end else if (clk_en_in) begin
            ret <= next_ret;
        end
    end

    // ======================================================================
    // outputs: plain copies of the registers above
    always_comb begin
        busy_out     = busy;
        wb_out       = wb;
        carry_wr_out = carry_wr;
        carry_out    = carry_q;
        ret_out      = ret;
    end
endmodule // srr_exec

//--- core/srr_pkg.sv
// package: constants, encodings and carrier structs for the return/rotate executor
// ==========================================================================
package srr_pkg;
    // ======================================================================
    // widths
    localparam int INSN_W   = 14;
    localparam int DATA_W   = 8;
    localparam int FADDR_W  = 7;
    localparam int PC_W     = 13;

    // ======================================================================
    // encodings
    localparam logic [3:0]  OP_RETLIT_TOP  = 4'hD;     // 11 01xx
    localparam logic [5:0]  OP_ROTL_TOP    = 6'h0D;    // 00 1101
    localparam logic [13:0] OP_RETURN      = 14'h0008;
    localparam int          LIT_LSB        = 0;
    localparam int          FADDR_LSB      = 0;
    localparam int          DEST_BIT       = 7;
    localparam int          MSB_BIT        = 7;
    localparam int          RET_CYCLES     = 2;

    // ======================================================================
    // carriers
    typedef struct packed {
        logic               wr_acc;
        logic               wr_file;
        logic [FADDR_W-1:0] file_addr;
        logic [DATA_W-1:0]  data;
    } srr_wb_t;

    typedef struct packed {
        logic            pop;
        logic [PC_W-1:0] pc;
    } srr_ret_t;

    typedef enum logic [1:0] {
        SRR_IDLE   = 2'b00,
        SRR_RETURN = 2'b01
    } srr_state_t;
endpackage

//--- core/srr_rotate.sv
// rotate-left-through-carry datapath
`timescale 1ns/1ps
module srr_rotate
    import srr_pkg::*;
#(
    parameter int WIDTH = DATA_W
) (
    // operand
    input  wire logic [WIDTH-1:0] value_in,
    input  wire logic             carry_in,
    // result
    output logic      [WIDTH-1:0] result_out,
    output logic                  carry_out
);
    // a one-bit rotate would have no bit to shift in from below
    if (WIDTH < 2) begin : g_bad_width
        $error("srr_rotate: WIDTH must be at least 2");
    end

    always_comb begin
        result_out = {value_in[WIDTH-2:0], carry_in};
        carry_out  = value_in[WIDTH-1];
    end
endmodule // srr_rotate

//--- tb/srr_exec_props.sv
// checker: port-level properties of the return/rotate executor
`timescale 1ns/1ps
module srr_exec_props
    import srr_pkg::*;
(
    input wire logic              ref_clk_in,
    input wire logic              rst_in,
    input wire logic              clk_en_in,
    input wire logic              insn_valid_in,
    input wire logic [INSN_W-1:0] insn_in,
    input wire logic [DATA_W-1:0] file_rd_data_in,
    input wire logic              carry_in,
    input wire logic [PC_W-1:0]   stack_top_entry_in,
    input wire logic              busy_out,
    input wire srr_wb_t           wb_out,
    input wire logic              carry_wr_out,
    input wire logic              carry_out,
    input wire srr_ret_t          ret_out
);
    logic [INSN_W-1:0] q_i;
    logic [PC_W-1:0]   q_s;
    logic [DATA_W-1:0] q_f;
    logic              q_c;
    // ==================================================================
    // operand history, so results can be tied to their cause
    always_ff @(posedge ref_clk_in) begin
        {q_i, q_s, q_f, q_c} <= {insn_in, stack_top_entry_in, file_rd_data_in, carry_in};
    end
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    sequence s_take;  clk_en_in && insn_valid_in && !busy_out; endsequence
    sequence s_lit;   s_take ##0 insn_in[13:10] == OP_RETLIT_TOP; endsequence
    sequence s_plain; s_take ##0 insn_in == OP_RETURN; endsequence
    sequence s_rot;   s_take ##0 insn_in[13:8] == OP_ROTL_TOP; endsequence
    lit_acc_a: assert property (s_lit |=> wb_out.wr_acc && wb_out.data == q_i[7:0])
        else $error("literal not loaded");
    lit_pop_a: assert property (s_lit |=> ret_out.pop && ret_out.pc == q_s)
        else $error("literal return pop wrong");
    lit_two_a: assert property (s_lit |=> busy_out ##1 (!busy_out || !$past(clk_en_in)))
        else $error("literal return not two cycles");
    plain_pop_a: assert property (s_plain |=> ret_out.pop && ret_out.pc == q_s && !wb_out.wr_acc)
        else $error("plain return pop wrong");
    plain_two_a: assert property (s_plain |=> busy_out
        ##1 (!$past(clk_en_in) || (!busy_out && !ret_out.pop)))
        else $error("plain return not two cycles");
    flags_kept_a: assert property ((s_lit or s_plain) |=> !carry_wr_out)
        else $error("return touched carry");
    rot_value_a: assert property (s_rot |=> carry_wr_out && carry_out == q_f[7]
        && wb_out.data == {q_f[6:0], q_c} && wb_out.file_addr == q_i[6:0])
        else $error("rotate result wrong");
    rot_dest_a: assert property (s_rot |=> wb_out.wr_file == q_i[7] && wb_out.wr_acc == !q_i[7])
        else $error("rotate destination wrong");
    dead_cycle_a: assert property (busy_out && clk_en_in |=> !ret_out.pop && !wb_out.wr_acc
        && !wb_out.wr_file && !carry_wr_out)
        else $error("work during dead cycle");
endmodule // srr_exec_props
bind srr_exec srr_exec_props u_props (.*);

//--- tb/testbench.sv
// testbench: directed scenarios for the return/rotate executor
`timescale 1ns/1ps
module testbench
    import srr_pkg::*;
;
    logic ref_clk_in = 1'b0, rst_in = 1'b1, clk_en_in = 1'b1, insn_valid_in = 1'b0, carry_in = 1'b0;
    logic [13:0] insn_in = 14'h0000;
    logic [7:0]  file_rd_data_in = 8'h00;
    logic [12:0] stack_top_entry_in = 13'h0000;
    logic        busy_out, carry_wr_out, carry_out;
    srr_wb_t     wb_out;
    srr_ret_t    ret_out;
    int          fail_count = 0, n_checks = 0;
    srr_exec uut (.*);
    initial forever #5 ref_clk_in = ~ref_clk_in;
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // data is only meaningful while a write strobe is up
    task look(input logic [26:0] e);
        chk({wb_out.wr_acc, wb_out.wr_file, (wb_out.wr_acc | wb_out.wr_file) ? wb_out.data : 8'h00,
             ret_out, busy_out, carry_wr_out, carry_out}, {5'h00, e});
    endtask
    task go(input logic [13:0] i, input logic [7:0] f, input logic c, input logic [12:0] s);
        {insn_valid_in, insn_in, file_rd_data_in, carry_in, stack_top_entry_in} = {1'b1, i, f, c, s};
        @(negedge ref_clk_in);
    endtask
    task t_rotate;
        go(14'h0D85, 8'h81, 1'b0, 13'h0000);
        look({2'b01, 8'h02, 14'h0000, 3'b011});
        chk(wb_out.file_addr, 7'h05);
        go(14'h0D26, 8'h66, 1'b1, 13'h0000);
        look({2'b10, 8'hCD, 14'h0000, 3'b010});
        chk(wb_out.file_addr, 7'h26);
        insn_valid_in = 1'b0;
        $display("rotate test done");
    endtask
    // a computed jump indexes a run of literal returns: each entry must yield its value
    task t_table;
        logic [7:0] k [3] = '{8'h00, 8'hFF, 8'h3C};
        for (int n = 0; n < 3; n++) begin
            @(negedge ref_clk_in);
            go({4'hD, n[1:0], k[n]}, 8'h55, 1'b1, {5'h10, k[n]});
            look({2'b10, k[n], 1'b1, 5'h10, k[n], 3'b100});
            // a rotate offered in the dead slot must be dropped
            go(14'h0DA0, 8'hFF, 1'b1, 13'h0000);
            look({27'h0});
            insn_valid_in = 1'b0;
        end
        $display("table test done");
    endtask
    task t_return;
        @(negedge ref_clk_in);
        go(14'h0008, 8'hFF, 1'b1, 13'h1FFF);
        insn_valid_in = 1'b0;
        look({2'b00, 8'h00, 1'b1, 13'h1FFF, 3'b100});
        @(negedge ref_clk_in);
        look({27'h0});
        $display("return test done");
    endtask
    // a low enable must hold every output, strobes included
    task t_freeze;
        clk_en_in = 1'b0;
        go(14'h0D85, 8'h81, 1'b0, 13'h0000);
        look({27'h0});
        clk_en_in = 1'b1;
        @(negedge ref_clk_in);
        look({2'b01, 8'h02, 14'h0000, 3'b011});
        {clk_en_in, insn_valid_in} = 2'b00;
        @(negedge ref_clk_in);
        look({2'b01, 8'h02, 14'h0000, 3'b011});
        clk_en_in = 1'b1;
        @(negedge ref_clk_in);
        look({27'h1});
        $display("enable test done");
    endtask
    // reset in mid-run clears the held carry; the next edge may take work
    task t_reset;
        go(14'h0D85, 8'h81, 1'b0, 13'h0000);
        rst_in = 1'b1;
        go(14'h0D85, 8'h81, 1'b0, 13'h0000);
        look({27'h0});
        rst_in = 1'b0;
        go(14'h3412, 8'h00, 1'b0, 13'h0ABC);
        look({2'b10, 8'h12, 1'b1, 13'h0ABC, 3'b100});
        insn_valid_in = 1'b0;
        @(negedge ref_clk_in);
        look({27'h0});
        $display("reset test done");
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // ======================================================================
    // main sequence and watchdog
    initial begin
        repeat (4) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        rst_in = 1'b0;
        @(negedge ref_clk_in);
        t_rotate;
        t_table;
        t_return;
        t_freeze;
        t_reset;
        end_of_test;
    end
    initial begin
        #2000;
        fail_count++;
        end_of_test;
    end
endmodule // testbench
